// [hdl/dpll_ref_path_regs.svh]
// Constants for the reference path control block: timing, slope steps, codes.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef DPLL_REF_PATH_REGS_SVH
`define DPLL_REF_PATH_REGS_SVH
`define CLK_PERIOD_NS 32'h0000_0008
`define TICK_TIME_US 32'h0000_03E8
`define TICK_CYCLES (`TICK_TIME_US * 32'h0000_03E8 / `CLK_PERIOD_NS)
// Slope steps in femtoseconds of phase per 1 ms tick.
`define SLOPE_61US 32'h03A2_C940
`define SLOPE_885NS 32'h000D_8108
`define SLOPE_7U5S 32'h0072_70E0
`define SLOPE_UNLIM 32'h5372_4E00
`define SLOPE_1NS 32'h0000_03E8
`define SLOPE_5NS 32'h0000_1388
`define SLOPE_10NS 32'h0000_2710
`define SLOPE_PROG_LSB_FS 8'h58
`define SLOPE_CODE_PROG 3'h7
`define AVG_SHIFT 5'h11
`define SYNC_FIRST_PIN 4'h2
`define SYNC_LAST_PIN 4'hD
`define COMP_8K_RATIO 3'h7
`define HF_SEL_DIV4 2'h1
`define HF_SEL_DIV5 2'h2
`define FREQ_8K 4'h0
`define FREQ_T1E1 4'h1
`define FREQ_6M48 4'h2
`define FREQ_2K 4'h9
`define FREQ_4K 4'hA
`define FREQ_1PPS 4'hB
`define FREQ_6M25 4'hC
`endif

// [hdl/dpll_ref_path_pkg.sv]
// Types shared by the reference path control block and its pre-divider.
// Assumes nothing beyond a SystemVerilog compiler.
package dpll_ref_path_pkg;
  typedef enum logic [2:0] {
    T3_FREE = 3'h1,
    T3_LOCK = 3'h2,
    T3_HOLD = 3'h4
  } third_state_t;
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_FREE = 3'h1,
    MODE_HOLD = 3'h2,
    MODE_LOCK = 3'h4
  } third_mode_t;
  typedef struct packed {
    logic [3:0] sel;
    logic holdover;
    logic freerun;
    logic signed [31:0] meas_phase;
  } main_loop_in_t;
  typedef struct packed {
    logic [1:0] highfreq_stage_select;
    logic direct_div;
    logic integer_divider_to_8k;
    logic [3:0] freq_code;
    logic [15:0] frac_num;
    logic [15:0] frac_den;
  } prediv_cfg_t;
endpackage

// [hdl/input_predivider.sv]
// One input pre-divider: high-frequency stage, fractional stage, integer stage.
// Assumes the reference level is already synchronised to the system clock.
`timescale 1ns/1ps
`include "dpll_ref_path_regs.svh"
module input_predivider import dpll_ref_path_pkg::*; #(
  parameter bit COMPOSITE = 1'b0,
  parameter bit HF_CAP = 1'b0
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic ce_i, // clock enable
  input wire logic ref_lvl_i, // synchronised reference level
  input wire prediv_cfg_t cfg_i, // divider settings
  input wire logic div_wr_lo_i, // write low byte of divide value
  input wire logic div_wr_hi_i, // write bits 14..8 and commit
  input wire logic [7:0] div_wdata_i, // divide value byte
  output logic [3:0] req_code_o, // loop-required frequency code
  output logic reserved_o, // code is reserved
  output logic pulse_o // divided reference pulse
);
  logic lvl_d_r, pulse_r;
  logic [2:0] hf_cnt_r, cmp_cnt_r;
  logic [16:0] acc_r;
  logic [7:0] lo_shadow_r;
  logic [14:0] integer_divide_value_r, dn_cnt_r;
  wire edge_w = ref_lvl_i & ~lvl_d_r;
  wire [2:0] hf_div = (!HF_CAP || COMPOSITE) ? 3'h0 :
    (cfg_i.highfreq_stage_select == `HF_SEL_DIV4) ? 3'h4 :
    (cfg_i.highfreq_stage_select == `HF_SEL_DIV5) ? 3'h5 : 3'h0;
  wire hf_p = edge_w & ((hf_div == 3'h0) | (hf_cnt_r == hf_div - 3'h1));
  wire fec_on = !COMPOSITE && (cfg_i.frac_num != 16'h0) && (cfg_i.frac_den != 16'h0);
  wire [16:0] acc_sum = acc_r + {1'b0, cfg_i.frac_den};
  wire fec_hit = acc_sum >= {1'b0, cfg_i.frac_num};
  wire fec_p = fec_on ? (hf_p & fec_hit) : hf_p;
  wire dn_on = !COMPOSITE && (cfg_i.direct_div | cfg_i.integer_divider_to_8k);
  wire dn_p = dn_on ? (fec_p & (dn_cnt_r == integer_divide_value_r)) : fec_p;
  wire cmp_p = edge_w & (cmp_cnt_r == `COMP_8K_RATIO);
  wire [3:0] code = COMPOSITE ? `FREQ_8K : cfg_i.freq_code;
  assign req_code_o = code;
  assign reserved_o = !(code == `FREQ_8K || code == `FREQ_T1E1 || code == `FREQ_6M48 ||
    code == `FREQ_2K || code == `FREQ_4K || code == `FREQ_1PPS || code == `FREQ_6M25);
  assign pulse_o = pulse_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_d_r <= 1'b0;
      pulse_r <= 1'b0;
      hf_cnt_r <= 3'h0;
      cmp_cnt_r <= 3'h0;
      acc_r <= 17'h0;
      lo_shadow_r <= 8'h0;
      integer_divide_value_r <= 15'h0;
      dn_cnt_r <= 15'h0;
    end else if (ce_i) begin
      lvl_d_r <= ref_lvl_i;
      pulse_r <= COMPOSITE ? cmp_p : dn_p;
      if (edge_w) cmp_cnt_r <= cmp_cnt_r + 3'h1;
      if (edge_w) hf_cnt_r <= hf_p ? 3'h0 : hf_cnt_r + 3'h1;
      if (hf_p && fec_on) acc_r <= fec_hit ? acc_sum - {1'b0, cfg_i.frac_num} : acc_sum;
      if (fec_p && dn_on) dn_cnt_r <= dn_p ? 15'h0 : dn_cnt_r + 15'h1;
      if (div_wr_lo_i) lo_shadow_r <= div_wdata_i;
      if (div_wr_hi_i) integer_divide_value_r <= {div_wdata_i[6:0], lo_shadow_r};
    end
  end
endmodule

// [hdl/dpll_reference_path_control.sv]
// Reference path control: glitch-free switching and phase slope limiting for
// the two main loops, third loop mode machine and holdover, frequency clamp,
// composite violation flags, sync pin selection and the input pre-dividers.
// Assumes loop measurements and monitor events arrive on ref_clk_i; only the
// reference pins and rstn_i are asynchronous.
`timescale 1ns/1ps
`include "dpll_ref_path_regs.svh"
module dpll_reference_path_control import dpll_ref_path_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic ref_clk_i, // system clock, 125 MHz
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic ce_i, // clock enable, freezes all state except the reset synchroniser when low
  input wire logic [13:0] ref_pin_i, // reference input pins
  input wire main_loop_in_t [1:0] loop_in_i, // main loop selection and phase
  input wire logic [1:0] glitchfree_switch_enable_i, // glitch-free switching on
  input wire logic [1:0] glitchfree_switch_freeze_i, // hold stored offset
  input wire logic [1:0][2:0] phase_slope_code_i, // slope limit code
  input wire logic [1:0][23:0] phase_slope_programmed_value_i, // programmed slope
  input wire logic [1:0][31:0] main_freq_i, // main loop frequency words
  input wire logic [31:0] freq_hard_limit_i, // hard frequency limit
  input wire logic [2:0] third_loop_mode_select_i, // third loop mode
  input wire logic third_loop_powerdown_i, // third loop power-down
  input wire logic third_loop_average_holdover_i, // averaged holdover
  input wire logic [3:0] third_sel_i, // third loop selected input, 0 none
  input wire logic third_sel_qualified_i, // selected input is qualified
  input wire logic signed [31:0] third_int_path_i, // third loop integral path
  input wire logic composite_low_tone_select_i, // expect 0.4 kHz tone
  input wire logic [1:0] composite_violation_evt_i, // structure violation seen
  input wire logic [1:0] composite_violation_clr_i, // clear violation flag
  input wire logic [1:0] composite_violation_mask_i, // 1 lets flag interrupt
  input wire logic [1:0][3:0] sync_select_i, // sync pin per main loop
  input wire prediv_cfg_t [13:0] prediv_cfg_i, // pre-divider settings
  input wire logic [13:0] div_wr_lo_i, // divide value low byte strobe
  input wire logic [13:0] div_wr_hi_i, // divide value high bits strobe
  input wire logic [7:0] div_wdata_i, // divide value byte
  output logic [1:0] glitchfree_switch_event_o, // switching event pulse
  output logic [1:0][31:0] phase_comp_o, // phase compensation, fs
  output logic [1:0][31:0] main_freq_o, // clamped main frequency
  output third_state_t third_state_o, // third loop state
  output logic [31:0] third_freq_o, // clamped third loop frequency
  output logic composite_tone_cfg_o, // tone setting to the receiver
  output logic composite_one_violation_o, // sticky flag, input one
  output logic composite_two_violation_o, // sticky flag, input two
  output logic int_req_o, // interrupt request, active high
  output logic [1:0] sync_pulse_o, // sync edge pulse per main loop
  output logic [13:0] div_pulse_o, // divided reference pulses
  output logic [13:0][3:0] req_code_o, // loop-required frequency codes
  output logic [13:0] freq_code_reserved_o // reserved code in use
);
  logic rst_meta_r, rst_n;
  logic [13:0] pin_meta_r, pin_r;
  logic [16:0] tick_cnt_r;
  wire tick = tick_cnt_r == TICK_CYCLES[16:0] - 17'h1;

  function automatic logic [31:0] slope_step(input logic [2:0] c, input logic [23:0] p);
    unique case (c)
      3'h0: slope_step = `SLOPE_61US;
      3'h1: slope_step = `SLOPE_885NS;
      3'h2: slope_step = `SLOPE_7U5S;
      3'h3: slope_step = `SLOPE_UNLIM;
      3'h4: slope_step = `SLOPE_1NS;
      3'h5: slope_step = `SLOPE_5NS;
      3'h6: slope_step = `SLOPE_10NS;
      default: slope_step = p * `SLOPE_PROG_LSB_FS;
    endcase
  endfunction

  function automatic logic [31:0] clamp(input logic signed [31:0] f,
                                        input logic signed [31:0] lim);
    if (f > lim) clamp = lim;
    else if (f < -lim) clamp = -lim;
    else clamp = f;
  endfunction

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // The tick paces slope limiting and averaging; 1 ms keeps step sizes exact.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 14'h0;
      pin_r <= 14'h0;
      tick_cnt_r <= 17'h0;
    end else if (ce_i) begin
      pin_meta_r <= ref_pin_i;
      pin_r <= pin_meta_r;
      tick_cnt_r <= tick ? 17'h0 : tick_cnt_r + 17'h1;
    end
  end

  // Main loops: glitch-free switching, slope limit, sync pin, frequency clamp.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : main_loop
      logic [3:0] sel_d_r;
      logic hold_d_r, free_d_r, evt_r, sync_d_r, sync_p_r;
      logic signed [31:0] offset_r, offset_nxt;
      logic [31:0] freq_r;
      wire main_loop_in_t li = loop_in_i[g];
      wire exit_idle = (hold_d_r | free_d_r) & ~(li.holdover | li.freerun);
      wire evt = glitchfree_switch_enable_i[g] & ((li.sel != sel_d_r) | exit_idle);
      wire take = evt & ~glitchfree_switch_freeze_i[g];
      wire [31:0] step = slope_step(phase_slope_code_i[g],
                                    phase_slope_programmed_value_i[g]);
      wire signed [31:0] sstep = step;
      wire sync_ok = sync_select_i[g] >= `SYNC_FIRST_PIN && sync_select_i[g] <= `SYNC_LAST_PIN;
      wire sync_lvl = sync_ok & pin_r[sync_select_i[g]];
      always_comb begin
        offset_nxt = offset_r;
        if (take) offset_nxt = li.meas_phase;
        else if (!glitchfree_switch_enable_i[g] && tick) begin
          if (offset_r > sstep) offset_nxt = offset_r - sstep;
          else if (offset_r < -sstep) offset_nxt = offset_r + sstep;
          else offset_nxt = 32'sh0;
        end
      end
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          sel_d_r <= 4'h0;
          hold_d_r <= 1'b0;
          free_d_r <= 1'b1;
          evt_r <= 1'b0;
          offset_r <= 32'sh0;
          freq_r <= 32'h0;
          sync_d_r <= 1'b0;
          sync_p_r <= 1'b0;
        end else if (ce_i) begin
          sel_d_r <= li.sel;
          hold_d_r <= li.holdover;
          free_d_r <= li.freerun;
          evt_r <= evt;
          offset_r <= offset_nxt;
          freq_r <= clamp(main_freq_i[g], freq_hard_limit_i);
          sync_d_r <= sync_lvl;
          sync_p_r <= sync_lvl & ~sync_d_r;
        end
      end
      assign glitchfree_switch_event_o[g] = evt_r;
      assign phase_comp_o[g] = offset_r;
      assign main_freq_o[g] = freq_r;
      assign sync_pulse_o[g] = sync_p_r;
    end
  endgenerate

  // Third loop operating mode.
  third_state_t state_r, state_nxt, auto_nxt;
  logic [3:0] t3_sel_d_r;
  logic signed [31:0] avg_r, hold_r, t3_raw;
  logic [31:0] t3_freq_r;
  wire sel_ok = (third_sel_i != 4'h0) & third_sel_qualified_i;
  wire leave_lock = ~sel_ok | (third_sel_i != t3_sel_d_r);
  wire enter_hold = (state_nxt == T3_HOLD) & (state_r != T3_HOLD);
  wire signed [31:0] avg_delta = (third_int_path_i - avg_r) >>> `AVG_SHIFT;

  always_comb begin
    auto_nxt = state_r;
    unique case (state_r)
      T3_FREE: if (sel_ok) auto_nxt = T3_LOCK;
      T3_LOCK: if (leave_lock) auto_nxt = T3_HOLD;
      T3_HOLD: if (sel_ok) auto_nxt = T3_LOCK;
      default: auto_nxt = T3_FREE;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    if (third_loop_powerdown_i) state_nxt = T3_FREE;
    else begin
      unique case (third_loop_mode_select_i)
        MODE_AUTO: state_nxt = auto_nxt;
        MODE_FREE: state_nxt = T3_FREE;
        MODE_HOLD: state_nxt = T3_HOLD;
        MODE_LOCK: state_nxt = T3_LOCK;
        default: state_nxt = state_r;
      endcase
    end
  end

  // Free-run carries no offset; an off loop also drives zero.
  always_comb begin
    t3_raw = 32'sh0;
    if (!third_loop_powerdown_i) begin
      if (state_r == T3_LOCK) t3_raw = third_int_path_i;
      else if (state_r == T3_HOLD) t3_raw = hold_r;
    end
  end

  // The average only learns while locked, so holdover never feeds itself.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= T3_FREE;
      t3_sel_d_r <= 4'h0;
      avg_r <= 32'sh0;
      hold_r <= 32'sh0;
      t3_freq_r <= 32'h0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      t3_sel_d_r <= third_sel_i;
      if (state_r == T3_LOCK && tick) avg_r <= avg_r + avg_delta;
      if (enter_hold)
        hold_r <= third_loop_average_holdover_i ? avg_r : third_int_path_i;
      t3_freq_r <= clamp(t3_raw, freq_hard_limit_i);
    end
  end
  assign third_state_o = state_r;
  assign third_freq_o = t3_freq_r;

  // Composite violation flags: an event in the clearing cycle wins.
  logic [1:0] viol_r;
  logic tone_r;
  wire [1:0] viol_nxt = composite_violation_evt_i | (viol_r & ~composite_violation_clr_i);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      viol_r <= 2'h0;
      tone_r <= 1'b0;
    end else if (ce_i) begin
      viol_r <= viol_nxt;
      tone_r <= composite_low_tone_select_i;
    end
  end
  assign composite_one_violation_o = viol_r[0];
  assign composite_two_violation_o = viol_r[1];
  assign int_req_o = |(viol_r & composite_violation_mask_i);
  assign composite_tone_cfg_o = tone_r;

  generate
    for (g = 0; g < 14; g++) begin : prediv
      input_predivider #(
        .COMPOSITE(g < 2),
        .HF_CAP(g >= 2 && g < 8)
      ) u_div (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .ref_lvl_i(pin_r[g]),
        .cfg_i(prediv_cfg_i[g]),
        .div_wr_lo_i(div_wr_lo_i[g]),
        .div_wr_hi_i(div_wr_hi_i[g]),
        .div_wdata_i(div_wdata_i),
        .req_code_o(req_code_o[g]),
        .reserved_o(freq_code_reserved_o[g]),
        .pulse_o(div_pulse_o[g])
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  // The offset register updates on the taking edge, so the next sampled edge
  // already shows it even if the clock enable drops in between.
  sequence s_event_taken;
    ce_i && glitchfree_switch_enable_i[0] && !glitchfree_switch_freeze_i[0]
      && loop_in_i[0].sel != main_loop[0].sel_d_r;
  endsequence
  sequence s_event_shown;
    phase_comp_o[0] == $past(loop_in_i[0].meas_phase) && glitchfree_switch_event_o[0];
  endsequence

  a_switch_capture: assert property (s_event_taken |=> s_event_shown)
    else $error("phase offset not captured on switching event");
  a_freeze_holds: assert property (ce_i && glitchfree_switch_freeze_i[0]
    && glitchfree_switch_enable_i[0] |=> $stable(phase_comp_o[0]))
    else $error("frozen offset changed");
  a_slew_zero: assert property (ce_i && tick && !glitchfree_switch_enable_i[0]
    && $signed(phase_comp_o[0]) > $signed(main_loop[0].step) |=>
    phase_comp_o[0] == $past(phase_comp_o[0]) - $past(main_loop[0].step))
    else $error("slew step wrong");
  a_freq_clamp: assert property (ce_i && $signed(main_freq_i[0]) > $signed(freq_hard_limit_i)
    |=> main_freq_o[0] == $past(freq_hard_limit_i))
    else $error("main frequency above hard limit");
  a_third_clamp: assert property (ce_i |=>
    $signed(third_freq_o) <= $signed($past(freq_hard_limit_i)))
    else $error("third loop frequency above hard limit");

  // Third loop mode and composite violation flag checks.
  a_powerdown_free: assert property (ce_i && third_loop_powerdown_i |=>
    third_state_o == T3_FREE ##1 !ce_i || third_freq_o == 32'h0)
    else $error("powered-down third loop not idle");
  sequence s_lock_lost;
    ce_i && !third_loop_powerdown_i && third_loop_mode_select_i == MODE_AUTO
      && state_r == T3_LOCK && !third_sel_qualified_i;
  endsequence
  a_lock_leave: assert property (s_lock_lost |=> third_state_o == T3_HOLD)
    else $error("locked state kept after disqualification");
  sequence s_forced_hold;
    ce_i && !third_loop_powerdown_i && third_loop_mode_select_i == MODE_HOLD;
  endsequence
  a_mode_forced: assert property (s_forced_hold |=> third_state_o == T3_HOLD)
    else $error("forced holdover mode not entered");
  a_free_zero: assert property (ce_i && third_state_o == T3_FREE |=>
    third_freq_o == 32'h0)
    else $error("free-run third loop output not zero");
  a_holdover_value: assert property (ce_i && enter_hold && !third_loop_average_holdover_i
    |=> hold_r == $past(third_int_path_i))
    else $error("holdover value not captured");
  a_viol_sticky: assert property (ce_i && composite_violation_evt_i[0]
    |=> composite_one_violation_o ##0 (composite_violation_mask_i[0] -> int_req_o))
    else $error("violation flag lost");
  a_viol_clear: assert property (ce_i && composite_violation_clr_i[0]
    && !composite_violation_evt_i[0] |=> !composite_one_violation_o)
    else $error("violation flag not cleared");

  // Sync and divider checks.
  a_sync_invalid: assert property (ce_i && sync_select_i[1] > `SYNC_LAST_PIN
    |=> !sync_pulse_o[1])
    else $error("sync pulse from an invalid pin code");
  // One instance is watched; every divider shares the same commit logic.
  a_divide_commit: assert property (ce_i && div_wr_hi_i[2] |=>
    prediv[2].u_div.integer_divide_value_r
      == {$past(div_wdata_i[6:0]), $past(prediv[2].u_div.lo_shadow_r)})
    else $error("divide value not committed");
endmodule

// [verif/ref_source.sv]
// Far-side model: the reference clocks arriving on the fourteen input pins.
// Assumes the bench calls burst; each pin rests low between bursts.
`timescale 1ns/1ps
module ref_source (
  output logic [13:0] pins_o // reference pin levels
);
  initial pins_o = 14'h0000;
  // Half periods are kept well above the system clock so every edge survives the synchroniser.
  task automatic burst(input int pin, input int n, input int half_ns);
    for (int k = 0; k < n; k++) begin
      #(half_ns) pins_o[pin] = 1'b1;
      #(half_ns) pins_o[pin] = 1'b0;
    end
  endtask
endmodule

// [verif/dpll_reference_path_control_bench.sv]
// Self-checking bench for the reference path control block.
// Assumes the package, the design and the reference source model are compiled first.
`timescale 1ns/1ps
`include "dpll_ref_path_regs.svh"
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end \
end
module dpll_reference_path_control_bench import dpll_ref_path_pkg::*; ;
  localparam int TICK = 16;
  localparam int LIMIT = 5000;
  logic clk, rstn, ce, t3_pdn, t3_avg, t3_qual, tone_sel, tone_cfg, v1, v2, irq;
  logic [13:0] pins, wr_lo, wr_hi, div_pls, rsvd;
  logic [1:0] sw_en, sw_frz, viol_evt, viol_clr, viol_mask, sw_evt, sync_pls;
  logic [1:0][2:0] slope_code;
  logic [1:0][23:0] slope_val;
  logic [1:0][31:0] mfreq, comp, mfreq_o;
  logic [1:0][3:0] sync_sel;
  logic [31:0] flim, t3_freq;
  logic [2:0] t3_mode;
  logic [3:0] t3_sel;
  logic signed [31:0] t3_int;
  logic [7:0] wdata;
  logic [13:0][3:0] req_code;
  main_loop_in_t [1:0] loop_in;
  prediv_cfg_t [13:0] pcfg;
  third_state_t t3_state;
  logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  third_state_t exp_st [4] = '{T3_FREE, T3_HOLD, T3_LOCK, T3_LOCK};
  int n_errors = 0, cmp_count = 0, cycles = 0, sync_cnt = 0, sync_bad = 0;
  int div_cnt [14];

  ref_source i_ref_source (.pins_o(pins));
  dpll_reference_path_control #(.TICK_CYCLES(TICK)) i_dpll_reference_path_control (
    .ref_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .ref_pin_i(pins), .loop_in_i(loop_in),
    .glitchfree_switch_enable_i(sw_en), .glitchfree_switch_freeze_i(sw_frz),
    .phase_slope_code_i(slope_code), .phase_slope_programmed_value_i(slope_val),
    .main_freq_i(mfreq), .freq_hard_limit_i(flim), .third_loop_mode_select_i(t3_mode),
    .third_loop_powerdown_i(t3_pdn), .third_loop_average_holdover_i(t3_avg),
    .third_sel_i(t3_sel), .third_sel_qualified_i(t3_qual), .third_int_path_i(t3_int),
    .composite_low_tone_select_i(tone_sel), .composite_violation_evt_i(viol_evt),
    .composite_violation_clr_i(viol_clr), .composite_violation_mask_i(viol_mask),
    .sync_select_i(sync_sel), .prediv_cfg_i(pcfg), .div_wr_lo_i(wr_lo), .div_wr_hi_i(wr_hi),
    .div_wdata_i(wdata), .glitchfree_switch_event_o(sw_evt), .phase_comp_o(comp),
    .main_freq_o(mfreq_o), .third_state_o(t3_state), .third_freq_o(t3_freq),
    .composite_tone_cfg_o(tone_cfg), .composite_one_violation_o(v1),
    .composite_two_violation_o(v2), .int_req_o(irq), .sync_pulse_o(sync_pls),
    .div_pulse_o(div_pls), .req_code_o(req_code), .freq_code_reserved_o(rsvd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Pulse counters run all the time; a hung sequence is cut off by the cycle ceiling.
  always @(posedge clk) begin
    for (int i = 0; i < 14; i++) div_cnt[i] += div_pls[i];
    sync_cnt += sync_pls[0];
    sync_bad += sync_pls[1];
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    {rstn, t3_avg, t3_qual, tone_sel, wr_lo, wr_hi, sw_en, sw_frz} = '0;
    {viol_evt, viol_clr, viol_mask, slope_val, mfreq, sync_sel, t3_mode, t3_sel} = '0;
    {t3_int, wdata, loop_in, pcfg} = '0;
    ce = 1'b1;
    t3_pdn = 1'b1;
    slope_code = {3'h7, 3'h7};
    flim = 32'h0010_0000;
    step(4);
    rstn = 1'b1;
    `CHK("third_state", T3_FREE, t3_state)
    `CHK("irq", 1'b0, irq)
    step(3);
    t3_pdn = 1'b0;
    sw_en = 2'b11;
    loop_in[0].sel = 4'h3;
    loop_in[0].meas_phase = 32'sd5000;
    step(1);
    `CHK("event", 2'b01, sw_evt)
    `CHK("comp", 32'h0000_1388, comp[0])
    step(1);
    `CHK("event", 2'b00, sw_evt)
    sw_frz[0] = 1'b1;
    loop_in[0].sel = 4'h5;
    loop_in[0].meas_phase = 32'sd777;
    step(1);
    `CHK("comp frozen", 32'h0000_1388, comp[0])
    sw_frz[0] = 1'b0;
    loop_in[0].holdover = 1'b1;
    step(2);
    loop_in[0].holdover = 1'b0;
    loop_in[0].meas_phase = 32'sd2000;
    step(1);
    `CHK("event", 2'b01, sw_evt)
    `CHK("comp", 32'h0000_07D0, comp[0])
    // The reset slope setting is the programmable one at zero, so nothing moves yet.
    sw_en[0] = 1'b0;
    step(3 * TICK);
    `CHK("comp held", 32'h0000_07D0, comp[0])
    slope_code[0] = 3'h4;
    step(3 * TICK);
    `CHK("comp slewed", 32'h0000_0000, comp[0])
    mfreq = {32'h000F_FFF0, 32'h0010_0005};
    step(2);
    `CHK("freq clamp", flim, mfreq_o[0])
    `CHK("freq pass", 32'h000F_FFF0, mfreq_o[1])
    t3_int = 32'sd1234;
    t3_sel = 4'h3;
    t3_qual = 1'b1;
    step(1);
    `CHK("third_state", T3_LOCK, t3_state)
    step(1);
    `CHK("third_freq", 32'h0000_04D2, t3_freq)
    t3_int = 32'sd999;
    step(1);
    t3_qual = 1'b0;
    step(1);
    `CHK("third_state", T3_HOLD, t3_state)
    t3_int = 32'sd5555;
    step(3);
    `CHK("third_freq", 32'h0000_03E7, t3_freq)
    t3_qual = 1'b1;
    step(1);
    `CHK("third_state", T3_LOCK, t3_state)
    t3_sel = 4'h4;
    step(1);
    `CHK("third_state", T3_HOLD, t3_state)
    t3_int = 32'sh0020_0000;
    step(3);
    `CHK("third_freq", flim, t3_freq)
    for (int k = 0; k < 4; k++) begin
      t3_mode = modes[k];
      step(1);
      `CHK("third_mode", exp_st[k], t3_state)
    end
    ce = 1'b0;
    t3_mode = 3'h1;
    step(1);
    `CHK("third_frozen", T3_LOCK, t3_state)
    ce = 1'b1;
    t3_mode = 3'h0;
    tone_sel = 1'b1;
    viol_mask = 2'b01;
    viol_evt = 2'b11;
    step(1);
    viol_evt = 2'b00;
    `CHK("flags", 2'b11, {v2, v1})
    `CHK("irq", 1'b1, irq)
    `CHK("tone", 1'b1, tone_cfg)
    viol_mask = 2'b00;
    viol_clr = 2'b01;
    step(1);
    `CHK("irq masked", 1'b0, irq)
    viol_clr = 2'b10;
    viol_evt = 2'b10;
    step(1);
    {viol_clr, viol_evt} = '0;
    `CHK("flags", 2'b10, {v2, v1})
    for (int c = 0; c < 16; c++) begin
      pcfg[4].freq_code = c[3:0];
      step(1);
      `CHK("req_code", c[3:0], req_code[4])
      `CHK("reserved", ((c >= 3 && c <= 8) || c >= 13), rsvd[4])
    end
    `CHK("req_code one", 4'h0, req_code[0])
    step(1);
    pcfg[2].direct_div = 1'b1;
    wdata = 8'h03;
    wr_lo[2] = 1'b1;
    step(1);
    wr_lo[2] = 1'b0;
    wdata = 8'h80;
    wr_hi[2] = 1'b1;
    step(1);
    wr_hi[2] = 1'b0;
    pcfg[3].highfreq_stage_select = `HF_SEL_DIV4;
    sync_sel = {4'hE, 4'h3};
    pcfg[5].frac_num = 16'h0003;
    pcfg[5].frac_den = 16'h0002;
    step(2);
    sync_cnt = 0;
    sync_bad = 0;
    foreach (div_cnt[i]) div_cnt[i] = 0;
    fork
      i_ref_source.burst(0, 16, 40);
      i_ref_source.burst(2, 16, 40);
      i_ref_source.burst(3, 16, 40);
      i_ref_source.burst(5, 12, 40);
    join
    step(10);
    `CHK("composite div", 2, div_cnt[0])
    `CHK("integer div", 4, div_cnt[2])
    `CHK("highfreq div", 4, div_cnt[3])
    `CHK("sync pulses", 16, sync_cnt)
    `CHK("sync invalid pin", 0, sync_bad)
    `CHK("fractional div", 8, div_cnt[5])
    wrap_up();
  end
endmodule
